/* File: common/sdio_pkg.sv */
// Purpose: Constants and types for the six-line digital I/O port.
// Assumes: 125 MHz system clock.
// Notes: Function codes are a local encoding; line numbers are 1-based at the ports.
package sdio_pkg;
  // ==========================================
  // Sizes
  localparam int NUM_LINES = 6;
  localparam int AUTO_LINES = 3;
  localparam int IDX_W = 3;
  // ==========================================
  // Function codes
  localparam logic [1:0] FN_AUTO = 2'h0;
  localparam logic [1:0] FN_DRIVE_HIGH = 2'h1;
  localparam logic [1:0] FN_DRIVE_LOW = 2'h2;
  localparam logic [1:0] FN_INPUT = 2'h3;
  // Edge selection for the trigger line
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // ==========================================
  // Error code and timing
  localparam logic [9:0] ERR_NOT_INPUT = 10'h1FC;
  localparam int CLK_MHZ = 125;
  localparam int PULSE_US = 10;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
  localparam logic [1:0] RESET_EDGE = EDGE_FALL;
  typedef enum logic [1:0] {SDIO_IDLE, SDIO_PULSE} sdio_pulse_state_t;
endpackage

/* File: hw/sdio_port.sv */
// Purpose: Six-line digital I/O port with automatic trigger and pulse roles.
// Assumes: Pins are sampled asynchronously; commands come from logic on CLK_SYS.
// Notes: Output enable is active low; a released line reads whatever the outside drives.
module sdio_port
  import sdio_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Function write: one-cycle strobe, line index 1..6
  input wire logic FUNC_WR,
  input wire logic [IDX_W-1:0] FUNC_LINE,
  input wire logic [1:0] FUNC_SEL,
  input wire logic RECALL,
  input wire logic [1:0] EDGE_SEL,
  // Data read: one-cycle strobe, line index 1..6
  input wire logic READ_REQ,
  input wire logic [IDX_W-1:0] READ_LINE,
  // Events from the instrument
  input wire logic MEAS_DONE,
  input wire logic OVERVOLTAGE_TRIP,
  input wire logic OVERCURRENT_TRIP,
  input wire logic OVERTEMP_TRIP,
  input wire logic SENSE_REVERSED,
  // Pins
  input wire logic [NUM_LINES-1:0] LINE_IN,
  output logic [NUM_LINES-1:0] LINE_OUT,
  output logic [NUM_LINES-1:0] LINE_OE_B,
  // Answers
  output logic [2*NUM_LINES-1:0] FUNC_STATE,
  output logic TRIG_OUT,
  output logic FUNC_REJECT,
  output logic READ_VALID,
  output logic READ_DATA,
  output logic READ_ERR,
  output logic [9:0] READ_ERR_CODE
);
  // ==========================================
  // Storage and synchronisers
  logic [1:0] func_reg [NUM_LINES];
  logic [1:0] edge_reg;
  logic [NUM_LINES-1:0] sync1_reg;
  logic [NUM_LINES-1:0] sync2_reg;
  logic trig_prev_reg;
  logic [CNT_W-1:0] cnt2_reg;
  logic [CNT_W-1:0] cnt3_reg;
  sdio_pulse_state_t st2_reg;
  sdio_pulse_state_t st3_reg;
  logic any_protection_trip;
  logic wr_ok;
  logic [IDX_W-1:0] wr_i;
  logic [IDX_W-1:0] rd_i;
  logic rd_in_range;

  assign wr_i = FUNC_LINE - IDX_W'(1);
  assign rd_i = READ_LINE - IDX_W'(1);
  assign rd_in_range = (READ_LINE >= IDX_W'(1)) && (READ_LINE <= IDX_W'(NUM_LINES));
  assign wr_ok = (FUNC_LINE >= IDX_W'(1)) && (FUNC_LINE <= IDX_W'(NUM_LINES))
                 && (FUNC_SEL != FN_AUTO || FUNC_LINE <= IDX_W'(AUTO_LINES));
  assign any_protection_trip = OVERVOLTAGE_TRIP | OVERCURRENT_TRIP | OVERTEMP_TRIP | SENSE_REVERSED;

  // ==========================================
  // Per-line function and pin drive
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
          func_reg[g] <= (g < AUTO_LINES) ? FN_AUTO : FN_INPUT;
        end else if (RECALL) begin
          func_reg[g] <= (g < AUTO_LINES) ? FN_AUTO : FN_INPUT;
        end else if (FUNC_WR && wr_ok && wr_i == IDX_W'(g)) begin
          func_reg[g] <= FUNC_SEL;
        end
      end

      always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
          LINE_OUT[g] <= 1'b0;
          LINE_OE_B[g] <= 1'b1;
          FUNC_STATE[2*g+1:2*g] <= (g < AUTO_LINES) ? FN_AUTO : FN_INPUT;
        end else begin
          FUNC_STATE[2*g+1:2*g] <= func_reg[g];
          unique case (func_reg[g])
            FN_DRIVE_HIGH: begin
              LINE_OUT[g] <= 1'b1;
              LINE_OE_B[g] <= 1'b0;
            end
            FN_DRIVE_LOW: begin
              LINE_OUT[g] <= 1'b0;
              LINE_OE_B[g] <= 1'b0;
            end
            FN_INPUT: begin
              LINE_OUT[g] <= 1'b0;
              LINE_OE_B[g] <= 1'b1;
            end
            FN_AUTO: begin
              // Line one listens; lines two and three carry the pulses
              LINE_OUT[g] <= (g == 1) ? (st2_reg == SDIO_PULSE) : (g == 2) ? (st3_reg == SDIO_PULSE) : 1'b0;
              LINE_OE_B[g] <= (g == 1 || g == 2) ? 1'b0 : 1'b1;
            end
          endcase
        end
      end
    end
  endgenerate

  // ==========================================
  // two-stage sync
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= LINE_IN;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================
  // Trigger input on line one
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      edge_reg <= RESET_EDGE;
    end else if (RECALL) begin
      edge_reg <= RESET_EDGE;
    end else if (EDGE_SEL != 2'h3) begin
      // Code 3 is unused; keeping the old setting stops it acting as both edges
      edge_reg <= EDGE_SEL;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      trig_prev_reg <= 1'b0;
      TRIG_OUT <= 1'b0;
    end else begin
      trig_prev_reg <= sync2_reg[0];
      TRIG_OUT <= (func_reg[0] == FN_AUTO) &&
                  (((edge_reg != EDGE_RISE) && trig_prev_reg && !sync2_reg[0]) ||
                   ((edge_reg != EDGE_FALL) && !trig_prev_reg && sync2_reg[0]));
    end
  end

  // ==========================================
  // Pulse timers; a new event during a pulse restarts nothing
  // completion pulse
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st2_reg <= SDIO_IDLE;
      cnt2_reg <= '0;
    end else if (st2_reg == SDIO_IDLE) begin
      cnt2_reg <= '0;
      if (MEAS_DONE && func_reg[1] == FN_AUTO) begin
        st2_reg <= SDIO_PULSE;
      end
    end else if (cnt2_reg == PULSE_LAST) begin
      st2_reg <= SDIO_IDLE;
    end else begin
      cnt2_reg <= cnt2_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st3_reg <= SDIO_IDLE;
      cnt3_reg <= '0;
    end else if (st3_reg == SDIO_IDLE) begin
      cnt3_reg <= '0;
      if (any_protection_trip && func_reg[2] == FN_AUTO) begin
        st3_reg <= SDIO_PULSE;
      end
    end else if (cnt3_reg == PULSE_LAST) begin
      st3_reg <= SDIO_IDLE;
    end else begin
      cnt3_reg <= cnt3_reg + CNT_W'(1);
    end
  end

  // ==========================================
  // Function write refusal and data read
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      FUNC_REJECT <= 1'b0;
    end else begin
      FUNC_REJECT <= FUNC_WR && !wr_ok && !RECALL;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      READ_VALID <= 1'b0;
      READ_DATA <= 1'b0;
      READ_ERR <= 1'b0;
      READ_ERR_CODE <= '0;
    end else begin
      READ_VALID <= 1'b0;
      READ_ERR <= 1'b0;
      READ_DATA <= 1'b0;
      READ_ERR_CODE <= '0;
      if (READ_REQ) begin
        if (rd_in_range && func_reg[rd_i] == FN_INPUT) begin
          READ_VALID <= 1'b1;
          READ_DATA <= sync2_reg[rd_i];
        end else begin
          READ_ERR <= 1'b1;
          READ_ERR_CODE <= ERR_NOT_INPUT;
        end
      end
    end
  end

  // ==========================================
  // Checks
  sequence s_pulse_hold;
    LINE_OUT[1] [*8];
  endsequence

  // Separate tally of the completion pulse, so the length checks do not lean on cnt2_reg
  logic [CNT_W-1:0] len2_reg;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      len2_reg <= '0;
    end else if (st2_reg == SDIO_PULSE) begin
      len2_reg <= len2_reg + CNT_W'(1);
    end else begin
      len2_reg <= '0;
    end
  end

  property p_auto_reject;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (FUNC_WR && !RECALL && FUNC_SEL == FN_AUTO && FUNC_LINE > 3'h3) |=> FUNC_REJECT;
  endproperty
  a_auto_reject: assert property (p_auto_reject) else $error("auto accepted above line three");

  property p_trig_rise;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (func_reg[0] == FN_AUTO && edge_reg == EDGE_RISE && $rose(sync2_reg[0])) |=> TRIG_OUT;
  endproperty
  a_trig_rise: assert property (p_trig_rise) else $error("rising edge missed");

  property p_pulse2;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (st2_reg == SDIO_IDLE && MEAS_DONE && func_reg[1] == FN_AUTO) ##1 (func_reg[1] == FN_AUTO)
      |=> s_pulse_hold;
  endproperty
  a_pulse2: assert property (p_pulse2) else $error("completion pulse too short");

  property p_pulse2_len;
    @(posedge CLK_SYS) disable iff (!RST_B)
      $fell(st2_reg == SDIO_PULSE) |-> (len2_reg == CNT_W'(PULSE_CYC));
  endproperty
  a_pulse2_len: assert property (p_pulse2_len) else $error("completion pulse length wrong");

  property p_pulse2_max;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (st2_reg == SDIO_PULSE) |-> (len2_reg < CNT_W'(PULSE_CYC));
  endproperty
  a_pulse2_max: assert property (p_pulse2_max) else $error("completion pulse too long");

  property p_pulse3;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (st3_reg == SDIO_IDLE && any_protection_trip && func_reg[2] == FN_AUTO) |=> (st3_reg == SDIO_PULSE);
  endproperty
  a_pulse3: assert property (p_pulse3) else $error("protection pulse missed");

  property p_high;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (func_reg[3] == FN_DRIVE_HIGH) |=> (LINE_OUT[3] && !LINE_OE_B[3]);
  endproperty
  a_high: assert property (p_high) else $error("line four not driven high");

  property p_low;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (func_reg[4] == FN_DRIVE_LOW) |=> (!LINE_OUT[4] && !LINE_OE_B[4]);
  endproperty
  a_low: assert property (p_low) else $error("line five not driven low");

  property p_input;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (func_reg[5] == FN_INPUT) |=> LINE_OE_B[5];
  endproperty
  a_input: assert property (p_input) else $error("input line still driven");

  property p_recall;
    @(posedge CLK_SYS) disable iff (!RST_B)
      RECALL |=> (func_reg[0] == FN_AUTO && func_reg[5] == FN_INPUT);
  endproperty
  a_recall: assert property (p_recall) else $error("recall defaults wrong");

  property p_read_err;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (READ_REQ && READ_LINE == 3'h1 && func_reg[0] != FN_INPUT) |=> (READ_ERR && !READ_VALID && READ_ERR_CODE == 10'h1FC);
  endproperty
  a_read_err: assert property (p_read_err) else $error("error 508 not raised");

  property p_read_data;
    @(posedge CLK_SYS) disable iff (!RST_B)
      (READ_REQ && READ_LINE == 3'h6 && func_reg[5] == FN_INPUT) |=> (READ_VALID && READ_DATA == $past(sync2_reg[5]));
  endproperty
  a_read_data: assert property (p_read_data) else $error("input data wrong");
endmodule

/* File: tb/sdio_equip.sv */
// Purpose: Outside test equipment on the six pins; drives lines, times pulses.
// Assumes: A pin the port drives shows the port's level, else the drv level.
// Notes: Widths are CLK_SYS cycles a pin stays high, latched on the fall.
module sdio_equip
  import sdio_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pins
  input wire logic [NUM_LINES-1:0] line_out,
  input wire logic [NUM_LINES-1:0] line_oe_b,
  input wire logic [NUM_LINES-1:0] drv,
  output logic [NUM_LINES-1:0] line_in,
  // Measured high widths of lines 2 and 3
  output logic [11:0] width2,
  output logic [11:0] width3
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cnt2 = 12'h000;
  logic [11:0] cnt3 = 12'h000;
  // ==========================================
  // Wire level: equipment yields wherever the port drives
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      line_in[i] = line_oe_b[i] ? drv[i] : line_out[i];
    end
  end
  // ==========================================
  // Pulse timers
  always @(posedge clk) begin
    cnt2 <= line_in[1] ? cnt2 + 12'h001 : 12'h000;
    cnt3 <= line_in[2] ? cnt3 + 12'h001 : 12'h000;
    if (!line_in[1] && cnt2 != 12'h000) width2 <= cnt2;
    if (!line_in[2] && cnt3 != 12'h000) width3 <= cnt3;
  end
endmodule

/* File: tb/sdio_port_test.sv */
// Purpose: Self-checking bench for the six-line digital I/O port.
// Assumes: Inputs change 1 ns after the rising edge; tasks start and end there.
// Notes: Pulse widths are timed by the equipment model on the wire.
module sdio_port_test;
  import sdio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic func_wr = 1'b0;
  logic [2:0] func_line = 3'h0;
  logic [1:0] func_sel = 2'h0;
  logic recall = 1'b0;
  logic [1:0] edge_sel = 2'h3;
  logic read_req = 1'b0;
  logic [2:0] read_line = 3'h0;
  logic [4:0] ev = 5'h00;
  logic [5:0] drv = 6'h00;
  logic [5:0] line_in, line_out, line_oe_b;
  logic [11:0] func_state, width2, width3;
  logic trig_out, func_reject, read_valid, read_data, read_err;
  logic [9:0] read_err_code;
  int error_cnt = 0;
  int n_compared = 0;
  int trig_n = 0;
  sdio_port dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .FUNC_WR(func_wr), .FUNC_LINE(func_line),
    .FUNC_SEL(func_sel), .RECALL(recall), .EDGE_SEL(edge_sel), .READ_REQ(read_req), .READ_LINE(read_line),
    .MEAS_DONE(ev[0]), .OVERVOLTAGE_TRIP(ev[1]), .OVERCURRENT_TRIP(ev[2]), .OVERTEMP_TRIP(ev[3]),
    .SENSE_REVERSED(ev[4]), .LINE_IN(line_in), .LINE_OUT(line_out), .LINE_OE_B(line_oe_b),
    .FUNC_STATE(func_state), .TRIG_OUT(trig_out), .FUNC_REJECT(func_reject), .READ_VALID(read_valid),
    .READ_DATA(read_data), .READ_ERR(read_err), .READ_ERR_CODE(read_err_code));
  sdio_equip eq_u (.clk(clk_sys), .line_out(line_out), .line_oe_b(line_oe_b), .drv(drv),
    .line_in(line_in), .width2(width2), .width3(width3));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (trig_out === 1'b1) trig_n++;
  end
  // ==========================================
  // Shared tasks
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [2:0] ln, input logic [1:0] sel, output logic rej);
    func_wr = 1'b1;
    func_line = ln;
    func_sel = sel;
    ticks(1);
    rej = func_reject;
    func_wr = 1'b0;
    ticks(2);
  endtask
  task automatic rd(input logic [2:0] ln, output logic v, output logic d, output logic e);
    read_req = 1'b1;
    read_line = ln;
    ticks(1);
    v = read_valid;
    d = read_data;
    e = read_err && read_err_code === ERR_NOT_INPUT;
    read_req = 1'b0;
    ticks(1);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_manual();
    logic r, v, d, e;
    chk(func_state === 12'hFC0 && line_oe_b === 6'h39 && line_out[2:1] === 2'h0, "defaults");
    wr(3'h4, FN_DRIVE_HIGH, r);
    chk(!r && line_out[3] && !line_oe_b[3] && func_state[7:6] === FN_DRIVE_HIGH, "high");
    wr(3'h5, FN_DRIVE_LOW, r);
    chk(!r && !line_out[4] && !line_oe_b[4] && func_state[9:8] === FN_DRIVE_LOW, "low");
    rd(3'h4, v, d, e);
    chk(e && !v, "read of output line");
    rd(3'h1, v, d, e);
    chk(e && !v, "read of auto line");
    for (int k = 0; k < 2; k++) begin
      drv[5] = k[0];
      ticks(3);
      rd(3'h6, v, d, e);
      chk(v && !e && d === k[0], "input level");
    end
    wr(3'h6, FN_DRIVE_HIGH, r);
    wr(3'h6, FN_INPUT, r);
    chk(line_oe_b[5] === 1'b1, "input released");
    $display("t_manual done");
  endtask
  task automatic t_reject();
    logic r;
    logic [11:0] keep;
    keep = {FN_INPUT, FN_DRIVE_LOW, FN_DRIVE_HIGH, FN_AUTO, FN_AUTO, FN_AUTO};
    for (int ln = 0; ln < 8; ln++) begin
      if (ln < 4 && ln > 0) continue;
      wr(3'(ln), ln == 0 || ln == 7 ? FN_INPUT : FN_AUTO, r);
      chk(r === 1'b1 && func_state === keep, "refused write");
    end
    $display("t_reject done");
  endtask
  task automatic t_trigger();
    logic [1:0] sel [4] = '{2'h3, EDGE_RISE, EDGE_BOTH, EDGE_FALL};
    int exp [4] = '{1, 1, 2, 1};
    for (int m = 0; m < 4; m++) begin
      edge_sel = sel[m];
      ticks(2);
      trig_n = 0;
      drv[0] = 1'b1;
      ticks(8);
      drv[0] = 1'b0;
      ticks(8);
      chk(trig_n == exp[m], "edge count");
    end
    edge_sel = EDGE_RISE;
    ticks(2);
    drv[0] = 1'b1;
    ticks(2);
    chk(trig_out === 1'b0, "early trigger");
    ticks(1);
    chk(trig_out === 1'b1, "trigger latency");
    drv[0] = 1'b0;
    $display("t_trigger done");
  endtask
  task automatic t_pulse();
    int n, k;
    for (int s = 0; s < 5; s++) begin
      k = s == 0 ? 1 : 2;
      n = 0;
      ev = 5'h01 << s;
      ticks(1);
      ev = 5'h00;
      while (line_in[k] !== 1'b1 && n < 10) begin
        ticks(1);
        n++;
      end
      chk(line_in[k] === 1'b1, "pulse start");
      // Second event while high must not stretch the pulse
      ev = 5'h01 << s;
      ticks(1);
      ev = 5'h00;
      while (line_in[k] === 1'b1 && n < 1400) begin
        ticks(1);
        n++;
      end
      if (n >= 1400) begin
        error_cnt++;
        end_of_test();
      end
      ticks(2);
      chk((k == 1 ? width2 : width3) === 12'(PULSE_CYC), "pulse width");
    end
    $display("t_pulse done");
  endtask
  task automatic t_recall();
    recall = 1'b1;
    ticks(1);
    recall = 1'b0;
    ticks(1);
    chk(func_state === 12'hFC0 && line_oe_b === 6'h39, "recall");
    $display("t_recall done");
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    ticks(2);
    t_manual();
    t_reject();
    t_trigger();
    t_pulse();
    t_recall();
    end_of_test();
  end
endmodule
